// File: cmcr_pkg.sv
// cmcr_pkg: offsets, field positions, reset values and encodings for the
// converter misc configuration register bank.
// assumes byte-wide registers on an 8-bit address configuration port.
package cmcr_pkg;

  // register offsets
  localparam logic [7:0] CMCR_OFS_STAMP  = 8'h3b;
  localparam logic [7:0] CMCR_OFS_EMPH   = 8'h48;
  localparam logic [7:0] CMCR_OFS_PUMP   = 8'h4f;
  localparam logic [7:0] CMCR_OFS_INMUX  = 8'h60;
  localparam logic [7:0] CMCR_OFS_CALEN  = 8'h61;

  // reset values
  localparam logic [7:0] CMCR_RST_STAMP  = 8'h00;
  localparam logic [7:0] CMCR_RST_EMPH   = 8'h00;
  localparam logic [7:0] CMCR_RST_PUMP   = 8'h13;
  localparam logic [7:0] CMCR_RST_INMUX  = 8'h01;
  localparam logic [7:0] CMCR_RST_CALEN  = 8'h01;

  // field positions
  localparam int CMCR_BIT_RECV_EN  = 0;
  localparam int CMCR_BIT_PECL     = 1;
  localparam int CMCR_BIT_BOOST    = 3;
  localparam int CMCR_BIT_SWAP     = 4;
  localparam int CMCR_BIT_CAL_EN   = 0;

  // writable masks: reserved bits read back as written
  localparam logic [7:0] CMCR_MASK_ALL   = 8'hff;

  // single-channel input codes
  localparam logic [1:0] CMCR_SEL_RSVD   = 2'h0;
  localparam logic [1:0] CMCR_SEL_A      = 2'h1;
  localparam logic [1:0] CMCR_SEL_B      = 2'h2;
  localparam logic [1:0] CMCR_SEL_AB     = 2'h3;

  // pump current codes
  localparam logic [2:0] CMCR_PUMP_NOM   = 3'h3;
  localparam logic [2:0] CMCR_PUMP_MAX   = 3'h7;

endpackage : cmcr_pkg

// File: cmcr_regs.sv
// cmcr_regs: misc configuration register bank of the converter: timestamp
// receiver control, lane pre-emphasis, pll pump current and input mux.
// assumes a single-clock register port; lane mode comes from logic on clk.
//
// Functional notes
// - timestamp control bit 1 puts the stamp receiver in pecl mode.
// - timestamp control bit 0 enables the stamp receiver; reset disabled.
// - pre-emphasis bit 3 adds boost: slightly stronger and longer emphasis.
// - pre-emphasis level bits 2:0 drive all 16 lanes alike.
// - pump current bits 2:0, codes 0..7 from -70% to +100%, reset 3.
// - dual modes, input select bit 4 swaps inputs between channels.
// - in single-channel modes the swap bit is ignored.
// - single input bits 1:0: 0 reserved, 1 a, 2 b, 3 interleaved.
// - outside single-channel modes the single input field is ignored.
// - clearing then setting calibration enable recalibrates with new settings.
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module cmcr_regs
  import cmcr_pkg::*;
#(
  parameter int LANES = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  // mode and calibration status from the core
  input  wire logic             lane_mode_single,
  input  wire logic             cal_done,
  // timestamp receiver
  output logic                  stamp_receiver_enable,
  output logic                  stamp_input_pecl_mode,
  // serializer lanes
  output logic [LANES*3-1:0]    lane_emphasis_level,
  output logic [LANES-1:0]      lane_emphasis_boost,
  // pll
  output logic [2:0]            pump_current_setting,
  // input routing in effect, its pending flag and calibration enable
  output logic                  chan_a_uses_input_b,
  output logic                  chan_b_uses_input_a,
  output logic                  single_uses_input_b,
  output logic                  route_pending,
  output logic                  cal_enable
);

  // address compare used by every register decode
  function automatic logic cmcr_hit(input logic [7:0] addr,
                                    input logic [7:0] ofs);
    return addr == ofs;
  endfunction : cmcr_hit

  // stored register bytes
  logic [7:0] stamp_ff;
  logic [7:0] emph_ff;
  logic [7:0] pump_ff;
  logic [7:0] inmux_ff;
  logic [7:0] calen_ff;

  // next values of the stored bytes
  logic [7:0] nxt_stamp;
  logic [7:0] nxt_emph;
  logic [7:0] nxt_pump;
  logic [7:0] nxt_inmux;
  logic [7:0] nxt_calen;

  // read path
  logic [7:0] rd_mux;
  logic [7:0] nxt_rdata;
  logic [7:0] rdata_ff;

  // routing in effect, frozen between calibrations
  logic       swap_eff_ff;
  logic       selb_eff_ff;
  logic       dual_il_eff_ff;
  logic       nxt_swap_eff;
  logic       nxt_selb_eff;
  logic       nxt_dual_il_eff;

  // mux written but not yet calibrated
  logic       pend_ff;
  logic       nxt_pend;

  // address decode
  wire logic hit_stamp = cmcr_hit(reg_addr, CMCR_OFS_STAMP);
  wire logic hit_emph  = cmcr_hit(reg_addr, CMCR_OFS_EMPH);
  wire logic hit_pump  = cmcr_hit(reg_addr, CMCR_OFS_PUMP);
  wire logic hit_inmux = cmcr_hit(reg_addr, CMCR_OFS_INMUX);
  wire logic hit_calen = cmcr_hit(reg_addr, CMCR_OFS_CALEN);
  wire logic hit_any   = hit_stamp || hit_emph || hit_pump ||
                         hit_inmux || hit_calen;

  // write enables per register
  wire logic stamp_wr  = reg_wr && hit_stamp;
  wire logic emph_wr   = reg_wr && hit_emph;
  wire logic pump_wr   = reg_wr && hit_pump;
  wire logic inmux_wr  = reg_wr && hit_inmux;
  wire logic calen_wr  = reg_wr && hit_calen;

  // rising cal enable starts a run with current settings
  wire logic cal_start = calen_wr && reg_wdata[CMCR_BIT_CAL_EN] &&
                         !calen_ff[CMCR_BIT_CAL_EN];

  // next register bytes; reserved bits are plain storage
  assign nxt_stamp = stamp_wr ? reg_wdata & CMCR_MASK_ALL : stamp_ff;
  assign nxt_emph  = emph_wr  ? reg_wdata & CMCR_MASK_ALL : emph_ff;
  assign nxt_pump  = pump_wr  ? reg_wdata & CMCR_MASK_ALL : pump_ff;
  assign nxt_inmux = inmux_wr ? reg_wdata & CMCR_MASK_ALL : inmux_ff;
  assign nxt_calen = calen_wr ? reg_wdata & CMCR_MASK_ALL : calen_ff;

  // timestamp control byte
  always_ff @(posedge clk) begin
    if (srst) stamp_ff <= CMCR_RST_STAMP;
    else stamp_ff <= nxt_stamp;
  end

  // pre-emphasis byte
  always_ff @(posedge clk) begin
    if (srst) emph_ff <= CMCR_RST_EMPH;
    else emph_ff <= nxt_emph;
  end

  // pump current byte, upper field resets nonzero
  always_ff @(posedge clk) begin
    if (srst) pump_ff <= CMCR_RST_PUMP;
    else pump_ff <= nxt_pump;
  end

  // input mux byte, not in effect until calibrated
  always_ff @(posedge clk) begin
    if (srst) inmux_ff <= CMCR_RST_INMUX;
    else inmux_ff <= nxt_inmux;
  end

  // calibration enable byte
  always_ff @(posedge clk) begin
    if (srst) calen_ff <= CMCR_RST_CALEN;
    else calen_ff <= nxt_calen;
  end

  // read mux, unmapped reads return zero
  assign rd_mux = hit_stamp ? stamp_ff :
                  hit_emph  ? emph_ff  :
                  hit_pump  ? pump_ff  :
                  hit_inmux ? inmux_ff :
                  hit_calen ? calen_ff : 8'h00;
  // data stands only in the cycle after the strobe
  assign nxt_rdata = reg_rd ? rd_mux : 8'h00;

  // registered read data
  always_ff @(posedge clk) begin
    if (srst) rdata_ff <= 8'h00;
    else rdata_ff <= nxt_rdata;
  end
  assign reg_rdata = rdata_ff;

  // routing snapshot taken only at calibration start
  assign nxt_swap_eff    = cal_start ? inmux_ff[CMCR_BIT_SWAP] :
                           swap_eff_ff;
  assign nxt_selb_eff    = cal_start ? inmux_ff[1:0] == CMCR_SEL_B :
                           selb_eff_ff;
  assign nxt_dual_il_eff = cal_start ? inmux_ff[1:0] == CMCR_SEL_AB :
                           dual_il_eff_ff;

  // effective routing flops, reset to no swap and input a
  always_ff @(posedge clk) begin
    if (srst) begin
      swap_eff_ff    <= 1'b0;
      selb_eff_ff    <= 1'b0;
      dual_il_eff_ff <= 1'b0;
    end else begin
      swap_eff_ff    <= nxt_swap_eff;
      selb_eff_ff    <= nxt_selb_eff;
      dual_il_eff_ff <= nxt_dual_il_eff;
    end
  end

  // pending flag: a mux write in the same cycle as done wins
  assign nxt_pend = inmux_wr               ? 1'b1 :
                    cal_start || cal_done  ? 1'b0 : pend_ff;

  // pending flag register
  always_ff @(posedge clk) begin
    if (srst) pend_ff <= 1'b0;
    else pend_ff <= nxt_pend;
  end
  assign route_pending = pend_ff;

  // timestamp receiver controls
  assign stamp_receiver_enable = stamp_ff[CMCR_BIT_RECV_EN];
  assign stamp_input_pecl_mode = stamp_ff[CMCR_BIT_PECL];

  // one emphasis setting fanned to every lane
  assign lane_emphasis_level = {LANES{emph_ff[2:0]}};
  assign lane_emphasis_boost = {LANES{emph_ff[CMCR_BIT_BOOST]}};

  // pump current code passed straight to the pll
  assign pump_current_setting = pump_ff[2:0];

  // routing: swap only in dual modes, single field only in single modes
  assign chan_a_uses_input_b = !lane_mode_single && swap_eff_ff;
  assign chan_b_uses_input_a = !lane_mode_single && swap_eff_ff;
  assign single_uses_input_b = lane_mode_single && selb_eff_ff &&
                               !dual_il_eff_ff;
  assign cal_enable = calen_ff[CMCR_BIT_CAL_EN];

  // checks
  stamp_follow_a: assert property (@(posedge clk) disable iff (srst)
    reg_wr && hit_stamp |=> stamp_receiver_enable == $past(reg_wdata[0]) &&
    stamp_input_pecl_mode == $past(reg_wdata[1]))
    else $error("stamp controls do not follow write");
  stamp_reset_a: assert property (@(posedge clk)
    $past(srst) |-> !stamp_receiver_enable)
    else $error("stamp receiver enabled after reset");
  boost_lanes_a: assert property (@(posedge clk) disable iff (srst)
    lane_emphasis_boost == {LANES{emph_ff[3]}})
    else $error("boost not common to all lanes");
  level_lanes_a: assert property (@(posedge clk) disable iff (srst)
    reg_wr && hit_emph |=> lane_emphasis_level[LANES*3-1 -: 3] ==
    $past(reg_wdata[2:0]) && lane_emphasis_level[2:0] ==
    $past(reg_wdata[2:0]))
    else $error("emphasis level not on all lanes");
  pump_reset_a: assert property (@(posedge clk)
    $past(srst) |-> pump_current_setting == 3'h3 && pump_ff == 8'h13)
    else $error("pump current reset wrong");
  swap_dual_a: assert property (@(posedge clk) disable iff (srst)
    cal_start && !lane_mode_single ##1 !lane_mode_single |->
    chan_a_uses_input_b == $past(inmux_ff[4]))
    else $error("swap not applied after calibration");
  swap_single_a: assert property (@(posedge clk) disable iff (srst)
    lane_mode_single |-> !chan_a_uses_input_b && !chan_b_uses_input_a)
    else $error("swap active in single mode");
  single_dual_a: assert property (@(posedge clk) disable iff (srst)
    !lane_mode_single |-> !single_uses_input_b)
    else $error("single field used in dual mode");
  route_hold_a: assert property (@(posedge clk) disable iff (srst)
    inmux_wr && !cal_start |=> $stable(swap_eff_ff) && route_pending)
    else $error("routing changed without calibration");
  cal_rerun_a: assert property (@(posedge clk) disable iff (srst)
    reg_wr && hit_calen && reg_wdata[0] && !calen_ff[0] |=> !route_pending)
    else $error("calibration start did not clear pending");

  // reset state of the outputs
  pecl_reset_a: assert property (@(posedge clk)
    $past(srst) |-> !stamp_input_pecl_mode)
    else $error("pecl mode on after reset");
  route_reset_a: assert property (@(posedge clk)
    $past(srst) |-> !chan_a_uses_input_b && !single_uses_input_b &&
    !route_pending && inmux_ff == 8'h01)
    else $error("input routing wrong after reset");
  calen_reset_a: assert property (@(posedge clk)
    $past(srst) |-> cal_enable)
    else $error("calibration enable clear after reset");
  emph_reset_a: assert property (@(posedge clk)
    $past(srst) |-> lane_emphasis_level == '0 && lane_emphasis_boost == '0)
    else $error("emphasis not off after reset");

  // field outputs follow the writes
  boost_follow_a: assert property (@(posedge clk) disable iff (srst)
    reg_wr && hit_emph |=> lane_emphasis_boost[0] == $past(reg_wdata[3]))
    else $error("boost does not follow write");
  pump_follow_a: assert property (@(posedge clk) disable iff (srst)
    reg_wr && hit_pump |=> pump_current_setting == $past(reg_wdata[2:0]))
    else $error("pump current does not follow write");
  calen_follow_a: assert property (@(posedge clk) disable iff (srst)
    reg_wr && hit_calen |=> cal_enable == $past(reg_wdata[0]))
    else $error("calibration enable does not follow write");

  // register port behaviour
  rdata_idle_a: assert property (@(posedge clk) disable iff (srst)
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  rdata_pump_a: assert property (@(posedge clk) disable iff (srst)
    reg_rd && hit_pump |=> reg_rdata == $past(pump_ff))
    else $error("pump read back wrong");
  unmapped_wr_a: assert property (@(posedge clk) disable iff (srst)
    reg_wr && !hit_any |=> $stable(stamp_ff) && $stable(emph_ff) &&
    $stable(pump_ff) && $stable(inmux_ff) && $stable(calen_ff))
    else $error("unmapped write changed a register");

  // routing rules
  swap_pair_a: assert property (@(posedge clk) disable iff (srst)
    chan_b_uses_input_a == chan_a_uses_input_b)
    else $error("swap not applied to both channels");
  single_sel_a: assert property (@(posedge clk) disable iff (srst)
    cal_start && lane_mode_single ##1 lane_mode_single |->
    single_uses_input_b == ($past(inmux_ff[1:0]) == 2'h2))
    else $error("single input not applied after calibration");
  pend_set_a: assert property (@(posedge clk) disable iff (srst)
    inmux_wr |=> route_pending)
    else $error("mux write did not raise pending");
  done_clear_a: assert property (@(posedge clk) disable iff (srst)
    cal_done && !inmux_wr |=> !route_pending)
    else $error("calibration done did not clear pending");
  done_route_a: assert property (@(posedge clk) disable iff (srst)
    !cal_start |=> $stable(swap_eff_ff) && $stable(selb_eff_ff) &&
    $stable(dual_il_eff_ff))
    else $error("routing changed without calibration start");

endmodule : cmcr_regs
`default_nettype wire

// File: converter_misc_config_regs_tb.sv
// converter_misc_config_regs_tb: self-checking bench for cmcr_regs.
// assumes read data one cycle after the strobe and writes that never stall.
`timescale 1ns/10ps
`default_nettype none
module converter_misc_config_regs_tb;
  import cmcr_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic        lane_mode_single = 1'b0, cal_done = 1'b0;
  logic        recv_en, pecl, a_b, b_a, s_b, pend, cal_en;
  logic [47:0] lvl;
  logic [15:0] boost;
  logic [2:0]  pump;
  int          num_errors = 0, checks_done = 0, mdl[int];
  logic [7:0]  ofs[6] = '{8'h3b, 8'h48, 8'h4f, 8'h60, 8'h61, 8'h70};
  logic [7:0]  d;
  logic        sw_snap = 1'b0;
  logic [1:0]  sel_snap = 2'h1;
  // clock at 200 MHz
  always #2.5 clk = ~clk;
  cmcr_regs #(.LANES(16)) u_cmcr_regs (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lane_mode_single(lane_mode_single), .cal_done(cal_done),
    .stamp_receiver_enable(recv_en), .stamp_input_pecl_mode(pecl),
    .lane_emphasis_level(lvl), .lane_emphasis_boost(boost),
    .pump_current_setting(pump), .chan_a_uses_input_b(a_b),
    .chan_b_uses_input_a(b_a), .single_uses_input_b(s_b),
    .route_pending(pend), .cal_enable(cal_en));
  // compare one value and count it
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  // one-cycle write, model follows mapped offsets
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (mdl.exists(int'(a))) mdl[int'(a)] = int'(v);
    #1;
  endtask : wr
  // one-cycle read, data checked in the following cycle
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, mdl.exists(int'(a)) ? mdl[int'(a)] : 0);
  endtask : rd
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // routing expected from the last calibrated snapshot
  task automatic chk_route();
    check(a_b, !lane_mode_single && sw_snap);
    check(b_a, !lane_mode_single && sw_snap);
    check(s_b, lane_mode_single && sel_snap == 2'h2);
  endtask : chk_route
  // watchdog
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
  // main sequence
  initial begin
    mdl[8'h3b] = 8'h00; mdl[8'h48] = 8'h00; mdl[8'h4f] = 8'h13;
    mdl[8'h60] = 8'h01; mdl[8'h61] = 8'h01;
    void'($urandom(44231));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    foreach (ofs[i]) rd(ofs[i]);
    check(pump, CMCR_PUMP_NOM);
    chk_route();
    $display("reset values done");
    for (int i = 0; i < 24; i++) begin
      d = 8'($urandom);
      d = (i % 3 == 0) ? d & 8'h03 : (i % 3 == 1) ? d & 8'h0f :
          {5'h02, d[2:0]};
      wr(ofs[i % 3], (i == 2) ? 8'h17 : d);
      wr(8'h70, d);
      d = 8'(mdl[8'h3b]);
      check({pecl, recv_en}, d[1:0]);
      d = 8'(mdl[8'h48]);
      check(lvl, {16{d[2:0]}});
      check(boost, {16{d[3]}});
      d = 8'(mdl[8'h4f]);
      check(pump, d[2:0]);
      rd(ofs[i % 3]);
      rd(8'h70);
    end
    $display("field outputs done");
    for (int i = 0; i < 16; i++) begin
      wr(8'h60, {3'h0, i[0], 2'h0, i[2:1]});
      check(pend, 1'b1);
      chk_route();
      if (i[1]) begin
        @(posedge clk);
        cal_done <= 1'b1;
        @(posedge clk);
        cal_done <= 1'b0;
        #1;
        check(pend, 1'b0);
        chk_route();
      end
      wr(8'h61, 8'h00);
      wr(8'h61, 8'h01);
      sw_snap = i[0];
      sel_snap = i[2:1];
      check(pend, 1'b0);
      check(cal_en, 1'b1);
      @(posedge clk);
      lane_mode_single <= i[3];
      @(posedge clk);
      #1;
      chk_route();
      rd(8'h60);
    end
    $display("input routing done");
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    mdl[8'h3b] = 8'h00; mdl[8'h48] = 8'h00; mdl[8'h4f] = 8'h13;
    mdl[8'h60] = 8'h01; mdl[8'h61] = 8'h01;
    sw_snap = 1'b0;
    sel_snap = 2'h1;
    foreach (ofs[i]) rd(ofs[i]);
    check(pend, 1'b0);
    chk_route();
    $display("mid-run reset done");
    conclude();
  end
endmodule : converter_misc_config_regs_tb
`default_nettype wire
